// File: hw/tsie_top.sv
// Top: APB registers, line driver enables, serial input capture
//
// What this block does
// - Enable pin low forces tip/ring to high impedance
// - Enable pin low overrides register tri-state setting
// - Enable pin high lets register tri-state decide
// - No elastic store and no interleaved bus: sample on line clock fall
// - Elastic store: sample on system clock fall
// - Interleaved bus mode uses system clock reference
// - Selectable matched termination, or termination off
//
// Added by the designer: the register addresses and the APB interface to the registers.
module tsie_top #(
  parameter int WORD_W = 8
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [1:0] line_driver_enable_pin,
  input logic [1:0] tx_line_clock,
  input logic tx_system_clock,
  input logic [1:0] tx_serial_in,
  output logic [1:0] line_tip_out,
  output logic [1:0] line_tip_oe,
  output logic [1:0] line_ring_out,
  output logic [1:0] line_ring_oe,
  output tsie_pkg::tsie_term_t [1:0] tx_term_sel,
  output tsie_pkg::tsie_term_t [1:0] rx_term_sel
);

  // ==========================================================
  // Enable pins cross into pclk
  logic [1:0] drv_en_s;

  tsie_sync #(.W(2)) u_en_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(line_driver_enable_pin),
    .q(drv_en_s)
  );

  // ==========================================================
  // Control state
  logic [1:0] es_q, es_d, tri_q, tri_d, sen_q, sen_d;
  logic ilv_q, ilv_d;
  logic [1:0] sys_sel;
  logic [3:0] src_en;

  // Elastic store or interleaved bus picks the system clock
  assign sys_sel = es_q | {2{ilv_q}};

  // Source s = 2*channel + (1 for system clock)
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      src_en[i] = sen_q[i / 2] & (sys_sel[i / 2] == (i % 2 == 1));
    end
  end

  // ==========================================================
  // Four samplers: line and system clock for each channel
  logic [3:0] req_tgl, req_s, ack_q, ack_d, take;
  logic [WORD_W-1:0] src_word [4];

  for (genvar s = 0; s < 4; s++) begin : g_src
    logic lclk;
    if (s % 2 == 1) begin : g_sys
      assign lclk = tx_system_clock;
    end else begin : g_line
      assign lclk = tx_line_clock[s / 2];
    end
    tsie_sampler #(.W(WORD_W)) u_smp (
      .link_clk(lclk),
      .presetn(presetn),
      .sample_en(src_en[s]),
      .serial_in(tx_serial_in[s / 2]),
      .ack_tgl(ack_q[s]),
      .req_tgl(req_tgl[s]),
      .word(src_word[s])
    );
  end

  tsie_sync #(.W(4)) u_req_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(req_tgl),
    .q(req_s)
  );

  // Every arriving word is acknowledged; unselected ones are dropped
  assign take = req_s ^ ack_q;
  assign ack_d = req_s;

  // ==========================================================
  // APB decode; no wait states
  logic wr_acc, rd_setup, rd_acc, mapped;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'h1;
  assign pslverr = psel & penable & ~mapped;

  // Only the six word offsets answer without error
  always_comb begin
    unique case (paddr)
      tsie_pkg::OFS_CTRL, tsie_pkg::OFS_TX_TERM,
      tsie_pkg::OFS_RX_IMP, tsie_pkg::OFS_STATUS,
      tsie_pkg::OFS_DATA0, tsie_pkg::OFS_DATA1: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  end

  // ==========================================================
  // Register next values
  tsie_pkg::tsie_term_t [1:0] tx_term_d, rx_term_d;
  logic [WORD_W-1:0] data_q [2];
  logic [WORD_W-1:0] data_d [2];
  logic [1:0] valid_q, valid_d;

  always_comb begin
    es_d = es_q;
    ilv_d = ilv_q;
    tri_d = tri_q;
    sen_d = sen_q;
    tx_term_d = tx_term_sel;
    rx_term_d = rx_term_sel;
    data_d = data_q;
    valid_d = valid_q;
    if (wr_acc && paddr == tsie_pkg::OFS_CTRL) begin
      es_d = pwdata[tsie_pkg::CTRL_ES_LSB +: 2];
      ilv_d = pwdata[tsie_pkg::CTRL_ILV_BIT];
      tri_d = pwdata[tsie_pkg::CTRL_TRI_LSB +: 2];
      sen_d = pwdata[tsie_pkg::CTRL_SEN_LSB +: 2];
    end
    for (int c = 0; c < 2; c++) begin
      // Matched termination per channel, code 0 is off
      if (wr_acc && paddr == tsie_pkg::OFS_TX_TERM) begin
        tx_term_d[c] = tsie_pkg::term_decode(
          pwdata[c * tsie_pkg::TERM_STRIDE +: 3]);
      end
      if (wr_acc && paddr == tsie_pkg::OFS_RX_IMP) begin
        rx_term_d[c] = tsie_pkg::term_decode(
          pwdata[c * tsie_pkg::TERM_STRIDE +: 3]);
      end
      // Reading a data word clears its valid flag
      if (rd_acc && paddr == (c == 0 ? tsie_pkg::OFS_DATA0
                                     : tsie_pkg::OFS_DATA1)) begin
        valid_d[c] = 1'h0;
      end
      // A new word beats the read clear in the same cycle
      if (take[c * 2 + int'(sys_sel[c])]) begin
        data_d[c] = src_word[c * 2 + int'(sys_sel[c])];
        valid_d[c] = 1'h1;
      end
    end
  end

  // ==========================================================
  // Driver enables and line data
  logic [1:0] oe_d, tip_d, ring_d;

  // Pin low wins over any register setting
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      oe_d[c] = drv_en_s[c] & ~tri_q[c];
      tip_d[c] = oe_d[c] & data_q[c][WORD_W-1];
      ring_d[c] = oe_d[c] & ~data_q[c][WORD_W-1];
    end
  end

  // ==========================================================
  // Read data is prepared in the setup cycle
  logic [31:0] prdata_d;

  always_comb begin
    prdata_d = prdata;
    if (rd_setup) begin
      prdata_d = '0;
      unique case (paddr)
        tsie_pkg::OFS_CTRL: begin
          prdata_d[tsie_pkg::CTRL_ES_LSB +: 2] = es_q;
          prdata_d[tsie_pkg::CTRL_ILV_BIT] = ilv_q;
          prdata_d[tsie_pkg::CTRL_TRI_LSB +: 2] = tri_q;
          prdata_d[tsie_pkg::CTRL_SEN_LSB +: 2] = sen_q;
        end
        tsie_pkg::OFS_TX_TERM: begin
          prdata_d[2:0] = 3'(tx_term_sel[0]);
          prdata_d[tsie_pkg::TERM_STRIDE +: 3] = 3'(tx_term_sel[1]);
        end
        tsie_pkg::OFS_RX_IMP: begin
          prdata_d[2:0] = 3'(rx_term_sel[0]);
          prdata_d[tsie_pkg::TERM_STRIDE +: 3] = 3'(rx_term_sel[1]);
        end
        tsie_pkg::OFS_STATUS: begin
          prdata_d[tsie_pkg::ST_PIN_LSB +: 2] = drv_en_s;
          prdata_d[tsie_pkg::ST_OE_LSB +: 2] = line_tip_oe;
          prdata_d[tsie_pkg::ST_VALID_LSB +: 2] = valid_q;
        end
        tsie_pkg::OFS_DATA0: prdata_d[WORD_W-1:0] = data_q[0];
        tsie_pkg::OFS_DATA1: prdata_d[WORD_W-1:0] = data_q[1];
        default: prdata_d = '0;
      endcase
    end
  end

  // ==========================================================
  // All pclk state; drivers come up tri-stated for safety
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      es_q <= tsie_pkg::ES_RST;
      ilv_q <= tsie_pkg::ILV_RST;
      tri_q <= tsie_pkg::TRI_RST;
      sen_q <= tsie_pkg::SEN_RST;
      tx_term_sel <= '{default: tsie_pkg::tsie_term_t'(tsie_pkg::TERM_RST)};
      rx_term_sel <= '{default: tsie_pkg::tsie_term_t'(tsie_pkg::TERM_RST)};
      data_q <= '{default: '0};
      valid_q <= '0;
      ack_q <= '0;
      line_tip_oe <= '0;
      line_ring_oe <= '0;
      line_tip_out <= '0;
      line_ring_out <= '0;
      prdata <= '0;
    end else begin
      es_q <= es_d;
      ilv_q <= ilv_d;
      tri_q <= tri_d;
      sen_q <= sen_d;
      tx_term_sel <= tx_term_d;
      rx_term_sel <= rx_term_d;
      data_q <= data_d;
      valid_q <= valid_d;
      ack_q <= ack_d;
      line_tip_oe <= oe_d;
      line_ring_oe <= oe_d;
      line_tip_out <= tip_d;
      line_ring_out <= ring_d;
      prdata <= prdata_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_pin_low_hiz;
    !drv_en_s[0] |=> !line_tip_oe[0] && !line_ring_oe[0];
  endproperty
  a_pin_low_hiz: assert property (p_pin_low_hiz)
    else $error("channel 0 driven while enable pin low");

  property p_reg_ignored;
    (!drv_en_s[1] && !tri_q[1]) ##1 !drv_en_s[1] |-> !line_tip_oe[1];
  endproperty
  a_reg_ignored: assert property (p_reg_ignored)
    else $error("register setting overrode low enable pin");

  property p_reg_tristate;
    (drv_en_s[0] && tri_q[0]) |=> !line_ring_oe[0];
  endproperty
  a_reg_tristate: assert property (p_reg_tristate)
    else $error("register tri-state not honoured");

  property p_reg_drive;
    (drv_en_s[1] && !tri_q[1])[*2] |-> line_tip_oe[1];
  endproperty
  a_reg_drive: assert property (p_reg_drive)
    else $error("driver not enabled with pin high and tri clear");

  property p_line_source;
    (take[0] && !sys_sel[0]) |=> valid_q[0]
      && data_q[0] == $past(src_word[0]);
  endproperty
  a_line_source: assert property (p_line_source)
    else $error("line clock word not captured");

  property p_sys_source;
    (take[3] && es_q[1]) |=> data_q[1] == $past(src_word[3]);
  endproperty
  a_sys_source: assert property (p_sys_source)
    else $error("system clock word not captured");

  property p_ilv_sysclk;
    ilv_q |-> !src_en[0] && !src_en[2];
  endproperty
  a_ilv_sysclk: assert property (p_ilv_sysclk)
    else $error("line clock sampler active in interleaved mode");

  sequence s_term_write;
    wr_acc && paddr == tsie_pkg::OFS_TX_TERM && pwdata[2:0] == 3'h2;
  endsequence
  property p_term_set;
    s_term_write |=> tx_term_sel[0] == tsie_pkg::TERM_E1_120;
  endproperty
  a_term_set: assert property (p_term_set)
    else $error("termination select not applied");

  property p_ch_indep;
    (take == 4'h1 && !(rd_acc && paddr == tsie_pkg::OFS_DATA1))
      |=> $stable(data_q[1]) && $stable(valid_q[1]);
  endproperty
  a_ch_indep: assert property (p_ch_indep)
    else $error("channel 0 traffic disturbed channel 1");

endmodule : tsie_top

// File: pkg/tsie_pkg.sv
// Package: register map, field layout, reset values and termination codes
package tsie_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX_TERM = 8'h04;
  localparam logic [7:0] OFS_RX_IMP = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DATA0 = 8'h10;
  localparam logic [7:0] OFS_DATA1 = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_ES_LSB = 0;
  localparam int CTRL_ILV_BIT = 2;
  localparam int CTRL_TRI_LSB = 4;
  localparam int CTRL_SEN_LSB = 8;
  localparam int TERM_STRIDE = 4;
  localparam int ST_PIN_LSB = 0;
  localparam int ST_OE_LSB = 4;
  localparam int ST_VALID_LSB = 8;

  // ==========================================================
  // Values after reset
  localparam logic [1:0] ES_RST = 2'h0;
  localparam logic ILV_RST = 1'h0;
  localparam logic [1:0] TRI_RST = 2'h3;
  localparam logic [1:0] SEN_RST = 2'h0;
  localparam logic [2:0] TERM_RST = 3'h0;

  // ==========================================================
  // Termination choices, off first
  typedef enum logic [2:0] {
    TERM_OFF,
    TERM_E1_75,
    TERM_E1_120,
    TERM_T1_100,
    TERM_J1_110
  } tsie_term_t;

  // Undefined codes fall back to no termination
  function automatic tsie_term_t term_decode(input logic [2:0] code);
    term_decode = (code <= 3'(TERM_J1_110)) ? tsie_term_t'(code)
                                             : TERM_OFF;
  endfunction : term_decode

endpackage : tsie_pkg

// File: hw/tsie_sync.sv
// Two-flop level synchroniser into the pclk domain
module tsie_sync #(
  parameter int W = 1
) (
  input logic clk,
  input logic rst_n,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : tsie_sync

// File: hw/tsie_sampler.sv
// Link-domain serial sampler with toggle handshake toward pclk
module tsie_sampler #(
  parameter int W = 8
) (
  input logic link_clk,
  input logic presetn,
  input logic sample_en,
  input logic serial_in,
  input logic ack_tgl,
  output logic req_tgl,
  output logic [W-1:0] word
);

  // ==========================================================
  // Reset and control synchronisers, all on the falling edge
  logic rst_meta_q, link_rst_n;
  logic en_meta_q, en_s_q, ack_meta_q, ack_s_q;

  // Release of reset is aligned to the link clock
  always_ff @(negedge link_clk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_q <= 1'h0;
      link_rst_n <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      link_rst_n <= rst_meta_q;
    end
  end

  // Level and toggle from pclk pass two flops
  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      en_meta_q <= 1'h0;
      en_s_q <= 1'h0;
      ack_meta_q <= 1'h0;
      ack_s_q <= 1'h0;
    end else begin
      en_meta_q <= sample_en;
      en_s_q <= en_meta_q;
      ack_meta_q <= ack_tgl;
      ack_s_q <= ack_meta_q;
    end
  end

  // ==========================================================
  // Shifter: first bit on the wire lands in the MSB
  logic [W-1:0] shift_q, shift_d, word_d;
  logic [$clog2(W)-1:0] cnt_q, cnt_d;
  logic req_d;

  // Shifts at whatever line rate the far end clocks
  always_comb begin
    shift_d = shift_q;
    cnt_d = '0;
    word_d = word;
    req_d = req_tgl;
    if (en_s_q) begin
      shift_d = {shift_q[W-2:0], serial_in};
      cnt_d = cnt_q + 1'h1;
      if (cnt_q == ($clog2(W))'(W - 1)) begin
        cnt_d = '0;
        // Word is dropped while pclk still owns the last one
        if (req_tgl == ack_s_q) begin
          word_d = shift_d;
          req_d = ~req_tgl;
        end
      end
    end
  end

  // Sampled on the falling edge of the link clock
  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_q <= '0;
      cnt_q <= '0;
      word <= '0;
      req_tgl <= 1'h0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      word <= word_d;
      req_tgl <= req_d;
    end
  end

endmodule : tsie_sampler

// File: bench/tsie_framer_model.sv
// Far-end framer model: one link clock and its serial data line
module tsie_framer_model (
  output logic clk_out,
  output logic data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle state: clock parked low between frames
  initial begin
    clk_out = 1'h0;
    data_out = 1'h0;
  end

  // ==========================================================
  // One 12 ns clock per bit, MSB first; data launched on the rise so it
  // is stable around the falling sample edge
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      clk_out = 1'h1;
      data_out = b[i];
      #6;
      clk_out = 1'h0;
      #6;
    end
    // Hold time over: show the inverse so a stale value never matches
    data_out = ~data_out;
  endtask : send_bits
endmodule : tsie_framer_model

// File: bench/tb_top.sv
// Self-checking bench: APB registers, driver enables, serial capture
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] en_pin, lclk, ldata, use_sys, ser;
  logic [1:0] tip, tip_oe, ring, ring_oe;
  logic sclk, sdata;
  tsie_pkg::tsie_term_t [1:0] tx_term, rx_term;
  int n_fail, cmp_count, cycles;

  // Selected source feeds each channel's serial pin
  assign ser[0] = use_sys[0] ? sdata : ldata[0];
  assign ser[1] = use_sys[1] ? sdata : ldata[1];

  initial pclk = 1'h0;
  always #20 pclk = ~pclk;

  tsie_top #(.WORD_W(8)) tsie_top_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .line_driver_enable_pin(en_pin),
    .tx_line_clock(lclk),
    .tx_system_clock(sclk),
    .tx_serial_in(ser),
    .line_tip_out(tip),
    .line_tip_oe(tip_oe),
    .line_ring_out(ring),
    .line_ring_oe(ring_oe),
    .tx_term_sel(tx_term),
    .rx_term_sel(rx_term)
  );
  tsie_framer_model line0_inst (.clk_out(lclk[0]), .data_out(ldata[0]));
  tsie_framer_model line1_inst (.clk_out(lclk[1]), .data_out(ldata[1]));
  tsie_framer_model sys_inst (.clk_out(sclk), .data_out(sdata));

  // ==========================================================
  // Verdict and hang guard
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // Compare tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH reg t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_port(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH port t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_port

  // ==========================================================
  // APB master: hold the request until pready is seen high
  task automatic apb_xfer(input logic [7:0] a, input logic w,
                          input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb_xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    apb_xfer(a, 1'h0, 32'h0);
    chk_reg(rd, exp);
    chk_port(6'(err), 6'(exp_err));
  endtask : rd_chk

  // Bits on the chosen source of one channel
  task automatic send_on(input int c, input logic s, input logic [7:0] b,
                         input int n);
    if (s) sys_inst.send_bits(b, n);
    else if (c == 1) line1_inst.send_bits(b, n);
    else line0_inst.send_bits(b, n);
  endtask : send_on

  // Undefined termination codes fall back to off
  function automatic logic [2:0] exp_term(input logic [2:0] c);
    exp_term = (c > 3'h4) ? 3'h0 : c;
  endfunction : exp_term

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] b;
    logic [7:0] da;
    logic [3:0] r;
    logic [2:0] c0, c1;
    logic [31:0] v;
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    en_pin = 2'h0;
    use_sys = 2'h0;
    void'($urandom(32'hE224));
    // Link logic needs falling edges while reset is held
    fork
      line0_inst.send_bits(8'h0, 4);
      line1_inst.send_bits(8'h0, 4);
      sys_inst.send_bits(8'h0, 4);
    join
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    fork
      line0_inst.send_bits(8'h0, 3);
      line1_inst.send_bits(8'h0, 3);
      sys_inst.send_bits(8'h0, 3);
    join
    rd_chk(tsie_pkg::OFS_CTRL, 32'(tsie_pkg::TRI_RST) << 4, 1'h0);
    rd_chk(tsie_pkg::OFS_STATUS, 32'h0, 1'h0);
    rd_chk(8'h18, 32'h0, 1'h1);
    chk_port(6'({tip_oe, ring_oe, tip, ring}), 6'h0);
    $display("test reset done");
    // Every pin and tri-state pair on both channels
    for (int i = 0; i < 16; i++) begin
      r = 4'(i);
      en_pin <= r[1:0];
      apb_write_ctrl(32'(r[3:2]) << 4);
      repeat (4) @(posedge pclk);
      chk_port(6'(tip_oe), 6'(r[1:0] & ~r[3:2]));
      chk_port(6'(ring_oe), 6'(r[1:0] & ~r[3:2]));
      chk_port(6'({tip & ~tip_oe, ring & ~ring_oe}), 6'h0);
      v = (32'(r[1:0] & ~r[3:2]) << 4) | 32'(r[1:0]);
      rd_chk(tsie_pkg::OFS_STATUS, v, 1'h0);
    end
    $display("test drivers done");
    // All eight codes on one channel, random on the other
    for (int i = 0; i < 8; i++) begin
      c0 = 3'(i);
      c1 = 3'($urandom);
      v = $urandom & 32'hFFFFFF88;
      apb_xfer(tsie_pkg::OFS_TX_TERM, 1'h1, v | {c1, 4'h0} | c0);
      apb_xfer(tsie_pkg::OFS_RX_IMP, 1'h1, v | {c0, 4'h0} | c1);
      v = {exp_term(c1), 4'h0} | exp_term(c0);
      rd_chk(tsie_pkg::OFS_TX_TERM, v, 1'h0);
      v = {exp_term(c0), 4'h0} | exp_term(c1);
      rd_chk(tsie_pkg::OFS_RX_IMP, v, 1'h0);
      chk_port(6'(tx_term), {exp_term(c1), exp_term(c0)});
      chk_port(6'(rx_term), {exp_term(c0), exp_term(c1)});
    end
    $display("test termination done");
    // Capture: line clock, elastic store, interleaved mode per channel
    en_pin <= 2'h3;
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 3; m++) begin
        use_sys[ch] <= (m != 0);
        v = (32'h100 << ch) | ((m == 1) ? (32'h1 << ch) : 32'h0);
        apb_write_ctrl(v | ((m == 2) ? 32'h4 : 32'h0));
        repeat (2) @(posedge pclk);
        b = 8'($urandom);
        send_on(ch, m != 0, 8'h0, 2);
        send_on(ch, m != 0, b, 8);
        repeat (12) @(posedge pclk);
        v = 32'h33 | (32'h100 << ch);
        rd_chk(tsie_pkg::OFS_STATUS, v, 1'h0);
        v = 32'(b);
        da = ch ? tsie_pkg::OFS_DATA1 : tsie_pkg::OFS_DATA0;
        rd_chk(da, v, 1'h0);
        chk_port(6'({tip[ch], ring[ch]}), 6'({b[7], ~b[7]}));
        rd_chk(tsie_pkg::OFS_STATUS, 32'h33, 1'h0);
        // Drop enable; a partial word is lost
        apb_write_ctrl(32'h0);
        send_on(ch, m != 0, 8'h0, 3);
      end
    end
    $display("test capture done");
    give_verdict();
  end

  task automatic apb_write_ctrl(input logic [31:0] d);
    apb_xfer(tsie_pkg::OFS_CTRL, 1'h1, d);
  endtask : apb_write_ctrl
endmodule : tb_top
